// File: src/dwms_pkg.sv
package dwms_pkg;
    // ************************************************************
    // Widths
    // ************************************************************
    localparam int                VDD_W        = 12;
    localparam int                CNT_W        = 16;
    localparam int                SCALE_W      = 7;
    // ************************************************************
    // Droop reference scaling: ref = sample * 97 / 100
    // ************************************************************
    localparam logic [SCALE_W-1:0] REF_NUM     = 7'h61;
    localparam logic [SCALE_W-1:0] REF_DEN     = 7'h64;
    // ************************************************************
    // Timing (clock 20 MHz)
    // ************************************************************
    localparam int                CLK_MHZ      = 20;
    localparam int                MIN_LOW_NS   = 1000;
    localparam int                DISS_US      = 177;
    localparam int                ENS_US       = 133;
    localparam int                WAKE_PER_NS  = 30000;
    localparam int                WAKE_ON_NS   = 500;
    localparam int                HOLD_US      = 1600;
    localparam logic [CNT_W-1:0]  MIN_LOW_CYC  = CNT_W'((MIN_LOW_NS * CLK_MHZ + 999) / 1000);
    localparam logic [CNT_W-1:0]  DISS_CYC     = CNT_W'(DISS_US * CLK_MHZ);
    localparam logic [CNT_W-1:0]  ENS_CYC      = CNT_W'(ENS_US * CLK_MHZ);
    localparam logic [CNT_W-1:0]  WAKE_PER_CYC = CNT_W'(WAKE_PER_NS * CLK_MHZ / 1000);
    localparam logic [CNT_W-1:0]  WAKE_ON_CYC  = CNT_W'(WAKE_ON_NS * CLK_MHZ / 1000);
    localparam int                HOLD_CYC     = HOLD_US * CLK_MHZ;
    // ************************************************************
    // Cycle counts
    // ************************************************************
    localparam logic [6:0]        DIS_COUNT    = 7'h3F;
    localparam logic [6:0]        EN_COUNT     = 7'h20;
endpackage

// File: src/dwms_cycle_qual.sv
module dwms_cycle_qual
    import dwms_pkg::*;
(
    input  wire logic clk_in,
    input  wire logic rst_n_in,
    input  wire logic run_in,
    input  wire logic wake_low_in,
    input  wire logic demag_end_in,
    output logic      qual_out
);
    typedef struct packed {
        logic [CNT_W-1:0] low_cnt;
        logic             qual;
    } dwms_cq_t;
    dwms_cq_t s_r, s_nxt;
    always_comb begin
        s_nxt      = s_r;
        s_nxt.qual = 1'b0;
        if (!run_in) begin
            s_nxt = '0;
        end else if (demag_end_in) begin
            // Trigger only at demag end after long enough low time
            s_nxt.qual    = (s_r.low_cnt > MIN_LOW_CYC);
            s_nxt.low_cnt = '0;
        end else if (wake_low_in) begin
            if (s_r.low_cnt != {CNT_W{1'b1}}) begin
                s_nxt.low_cnt = s_r.low_cnt + 1'b1;
            end
        end else begin
            s_nxt.low_cnt = '0;
        end
    end
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end
    assign qual_out = s_r.qual;
endmodule

// File: src/dwms_top.sv
// Function
// - All functions idle until lockout released
// - Stay running until lockout turn-off
// - Sample trigger at demag interval end
// - Qualify only after long enough low
// - Qualified cycle stores 97% of supply
// - Unqualified disturbances keep reference
// - Wake request when supply below reference
// - Wake request pulls wake line low
// - Short pulses repeat until cycle or lockout
// - Cycle after wake refreshes, stops pulses
// - Cycle during droop re-samples reference
// - Enable low after sustained slow cycles
// - Release enable after 32 fast cycles
// - Reference valid only within hold interval
// - Enable off at power-up; 63 slow cycles
// - Fast period clears disable count
// - Fast-cycle count cumulative while enable low
// - Wake leaves enable and counts alone
module dwms_top
    import dwms_pkg::*;
#(
    parameter int HOLD_CYCLES = HOLD_CYC
)(
    input  wire logic             CLK_IN,
    input  wire logic             RST_N_IN,
    input  wire logic             UNDERVOLTAGE_LOCKOUT_OK_IN,
    input  wire logic             WAKE_LOW_IN,
    input  wire logic             DEMAG_END_IN,
    input  wire logic [VDD_W-1:0] VDD_SAMPLE_IN,
    output logic                  WAKE_OUT,
    output logic                  WAKE_OE_OUT,
    output logic                  ENABLE_OUT,
    output logic                  ENABLE_OE_OUT,
    output logic                  REF_VALID_OUT,
    output logic [VDD_W-1:0]      DROOP_REF_OUT
);
    // ************************************************************
    // State
    // ************************************************************
    typedef enum logic [1:0] {
        DWMS_IDLE = 2'b01,
        DWMS_WAKE = 2'b10
    } dwms_st_t;
    typedef struct packed {
        logic [1:0]       undervoltage_lockout_sync;
        logic [1:0]       wake_sync;
        logic [1:0]       demag_sync;
        logic             running;
        dwms_st_t         st;
        logic [VDD_W-1:0] droop_ref;
        logic             ref_loaded;
        logic [31:0]      hold_cnt;
        logic             ref_valid;
        logic [CNT_W-1:0] per_cnt;
        logic [CNT_W-1:0] pulse_cnt;
        logic             wake_drive;
        logic [6:0]       dis_cnt;
        logic [6:0]       en_cnt;
        logic             ens_on;
    } dwms_s_t;
    dwms_s_t s_r, s_nxt;
    logic qual;
    logic [VDD_W-1:0]         scaled;
    logic                     droop;
    // ************************************************************
    // Helpers
    // ************************************************************
    // Widened before the product so 97 percent of full scale fits
    function automatic logic [VDD_W-1:0] dwms_scale_ref(input logic [VDD_W-1:0] smp);
        logic [VDD_W+SCALE_W-1:0] prod;
        logic [VDD_W+SCALE_W-1:0] quo;
        prod = (VDD_W+SCALE_W)'(smp) * (VDD_W+SCALE_W)'(REF_NUM);
        quo  = prod / (VDD_W+SCALE_W)'(REF_DEN);
        return quo[VDD_W-1:0];
    endfunction
    // ************************************************************
    // Power-cycle qualifier
    // ************************************************************
    dwms_cycle_qual u_qual (
        .clk_in       (CLK_IN),
        .rst_n_in     (RST_N_IN),
        .run_in       (s_r.running),
        .wake_low_in  (s_r.wake_sync[1] & ~s_r.wake_drive),
        .demag_end_in (s_r.demag_sync[1]),
        .qual_out     (qual)
    );
    always_comb begin
        scaled = dwms_scale_ref(VDD_SAMPLE_IN);
        droop  = s_r.ref_loaded && (VDD_SAMPLE_IN < s_r.droop_ref);
    end
    // ************************************************************
    // Sequencer
    // ************************************************************
    always_comb begin
        s_nxt = s_r;
        // ************************************************************
        // Input synchronisers
        // ************************************************************
        s_nxt.undervoltage_lockout_sync  = {s_r.undervoltage_lockout_sync[0], UNDERVOLTAGE_LOCKOUT_OK_IN};
        s_nxt.wake_sync  = {s_r.wake_sync[0], WAKE_LOW_IN};
        s_nxt.demag_sync = {s_r.demag_sync[0], DEMAG_END_IN};
        s_nxt.running    = s_r.undervoltage_lockout_sync[1];
        // ************************************************************
        // Lockout
        // ************************************************************
        // A supply sag drops every stored count, enable included
        if (!s_r.running) begin
            // Lockout: everything back to power-up state
            s_nxt.st         = DWMS_IDLE;
            s_nxt.droop_ref  = '0;
            s_nxt.ref_loaded = 1'b0;
            s_nxt.hold_cnt   = '0;
            s_nxt.ref_valid  = 1'b0;
            s_nxt.per_cnt    = '0;
            s_nxt.pulse_cnt  = '0;
            s_nxt.wake_drive = 1'b0;
            s_nxt.dis_cnt    = '0;
            s_nxt.en_cnt     = '0;
            s_nxt.ens_on     = 1'b0;
        end else begin
            // ************************************************************
            // Period and hold timers
            // ************************************************************
            // Timers saturate so a very long sleep never wraps to a short one
            if (s_r.per_cnt != {CNT_W{1'b1}}) begin
                s_nxt.per_cnt = s_r.per_cnt + 1'b1;
            end
            if (s_r.hold_cnt < 32'(HOLD_CYCLES)) begin
                s_nxt.hold_cnt = s_r.hold_cnt + 32'h1;
            end else begin
                s_nxt.ref_valid = 1'b0;
            end
            // ************************************************************
            // Refresh on qualified cycle
            // ************************************************************
            // Reference, timers and period classes move on one edge
            if (qual) begin
                s_nxt.droop_ref  = scaled[VDD_W-1:0];
                s_nxt.ref_loaded = 1'b1;
                s_nxt.ref_valid  = 1'b1;
                s_nxt.hold_cnt   = '0;
                s_nxt.per_cnt    = '0;
                s_nxt.st         = DWMS_IDLE;
                s_nxt.wake_drive = 1'b0;
                // Period classification; wake pulses never touch it
                if (s_r.per_cnt > DISS_CYC) begin
                    if (!s_r.ens_on) begin
                        if (s_r.dis_cnt + 7'h01 >= DIS_COUNT) begin
                            s_nxt.ens_on  = 1'b1;
                            s_nxt.dis_cnt = '0;
                            s_nxt.en_cnt  = '0;
                        end else begin
                            s_nxt.dis_cnt = s_r.dis_cnt + 7'h01;
                        end
                    end
                end else if (!s_r.ens_on) begin
                    s_nxt.dis_cnt = '0;
                end
                if (s_r.ens_on && s_r.per_cnt < ENS_CYC) begin
                    if (s_r.en_cnt + 7'h01 >= EN_COUNT) begin
                        s_nxt.ens_on = 1'b0;
                        s_nxt.en_cnt = '0;
                    end else begin
                        s_nxt.en_cnt = s_r.en_cnt + 7'h01;
                    end
                end
            end else begin
                // ************************************************************
                // Wake pulse generator
                // ************************************************************
                // Own pulses are masked at the qualifier, so they never refresh
                unique case (s_r.st)
                    DWMS_IDLE: begin
                        if (droop) begin
                            s_nxt.st         = DWMS_WAKE;
                            s_nxt.pulse_cnt  = '0;
                            s_nxt.wake_drive = 1'b1;
                        end
                    end
                    DWMS_WAKE: begin
                        // Counts and enable untouched while waking
                        if (s_r.pulse_cnt + 1'b1 >= WAKE_PER_CYC) begin
                            s_nxt.pulse_cnt  = '0;
                            s_nxt.wake_drive = 1'b1;
                        end else begin
                            s_nxt.pulse_cnt = s_r.pulse_cnt + 1'b1;
                            if (s_r.pulse_cnt + 1'b1 >= WAKE_ON_CYC) begin
                                s_nxt.wake_drive = 1'b0;
                            end
                        end
                    end
                endcase
            end
        end
    end
    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            s_r    <= '0;
            s_r.st <= DWMS_IDLE;
        end else begin
            s_r <= s_nxt;
        end
    end
    // ************************************************************
    // Open-drain pins
    // ************************************************************
    // Level fixed at zero; only the enables switch
    always_comb begin
        WAKE_OUT      = 1'b0;
        ENABLE_OUT    = 1'b0;
        WAKE_OE_OUT   = s_r.wake_drive;
        ENABLE_OE_OUT = s_r.ens_on;
        REF_VALID_OUT = s_r.ref_valid;
        DROOP_REF_OUT = s_r.droop_ref;
    end
endmodule

// File: tb/dwms_top_props.sv
module dwms_top_props
    import dwms_pkg::*;
#(
    parameter int HOLD_CYCLES = HOLD_CYC
)(
    input wire logic             CLK_IN,
    input wire logic             RST_N_IN,
    input wire logic             UNDERVOLTAGE_LOCKOUT_OK_IN,
    input wire logic             WAKE_LOW_IN,
    input wire logic             DEMAG_END_IN,
    input wire logic [VDD_W-1:0] VDD_SAMPLE_IN,
    input wire logic             WAKE_OUT,
    input wire logic             WAKE_OE_OUT,
    input wire logic             ENABLE_OUT,
    input wire logic             ENABLE_OE_OUT,
    input wire logic             REF_VALID_OUT,
    input wire logic [VDD_W-1:0] DROOP_REF_OUT
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [16:0] since_r;
    logic [16:0] gap_r;
    logic [18:0] scaled;
    logic        droop;
    logic        wk_ok;
    logic [9:0]  wgap_r;
    assign scaled = ({7'h00, VDD_SAMPLE_IN} * 19'h00061) / 19'h00064;
    assign droop = UNDERVOLTAGE_LOCKOUT_OK_IN && REF_VALID_OUT && (VDD_SAMPLE_IN < DROOP_REF_OUT);
    // A qual may cut a pulse short
    assign wk_ok = WAKE_OE_OUT || (since_r < 17'h0000C);
    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            since_r <= '1;
            gap_r   <= '0;
        end else if (DEMAG_END_IN) begin
            since_r <= '0;
            gap_r   <= since_r;
        end else if (since_r != '1) begin
            since_r <= since_r + 17'h00001;
        end
    end
    // Cycles since the last wake pulse; saturates so idle never matches
    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            wgap_r <= '1;
        end else if (WAKE_OE_OUT) begin
            wgap_r <= '0;
        end else if (wgap_r != '1) begin
            wgap_r <= wgap_r + 10'h001;
        end
    end
    default clocking @(posedge CLK_IN); endclocking
    default disable iff (!RST_N_IN);
    a_lockout_clear: assert property (!UNDERVOLTAGE_LOCKOUT_OK_IN [*5] |-> !WAKE_OE_OUT && !REF_VALID_OUT
        && !ENABLE_OE_OUT && !WAKE_OUT && !ENABLE_OUT && DROOP_REF_OUT == 12'h000)
        else $error("outputs not cleared in lockout");
    a_ref_only_qual: assert property ($changed(DROOP_REF_OUT) |-> DROOP_REF_OUT == 12'h000
        || (since_r >= 17'h00003 && since_r <= 17'h00007)) else $error("reference moved without cycle");
    a_ref_value: assert property ($changed(DROOP_REF_OUT) && DROOP_REF_OUT != 12'h000
        |-> DROOP_REF_OUT == $past(scaled[11:0])) else $error("reference not 97 percent");
    a_wake_start: assert property ($rose(droop) |=> WAKE_OE_OUT)
        else $error("no wake pulse on droop");
    a_pulse_width: assert property ($rose(WAKE_OE_OUT) |-> wk_ok [*8] ##1 wk_ok [*2]
        ##1 !WAKE_OE_OUT) else $error("wake pulse width wrong");
    a_pulse_repeat: assert property (wgap_r == 10'h24E |-> (WAKE_OE_OUT
        || since_r < 17'h00262 || !UNDERVOLTAGE_LOCKOUT_OK_IN)) else $error("wake pulse not repeated");
    a_enable_gap: assert property ($rose(ENABLE_OE_OUT) |-> gap_r > DISS_CYC)
        else $error("enable after fast period");
    a_valid_hold: assert property (since_r > HOLD_CYCLES + 8 |-> !REF_VALID_OUT)
        else $error("reference valid past hold");
    c_wake: cover property ($rose(WAKE_OE_OUT));
    c_stale: cover property ($fell(REF_VALID_OUT));
    c_ref: cover property ($changed(DROOP_REF_OUT));
endmodule
bind dwms_top dwms_top_props #(.HOLD_CYCLES(HOLD_CYCLES)) u_props (.CLK_IN, .RST_N_IN,
    .UNDERVOLTAGE_LOCKOUT_OK_IN, .WAKE_LOW_IN, .DEMAG_END_IN, .VDD_SAMPLE_IN, .WAKE_OUT, .WAKE_OE_OUT,
    .ENABLE_OUT, .ENABLE_OE_OUT, .REF_VALID_OUT, .DROOP_REF_OUT);

// File: tb/dwms_primary_model.sv
module dwms_primary_model (
    input  wire logic       clk,
    input  wire logic       kick,
    input  wire logic       respond,
    input  wire logic       wake_oe,
    input  wire logic [7:0] low_len,
    output logic            line_low,
    output logic            demag_end
);
    timeunit 1ns;
    timeprecision 1ns;
    int   n    = 0;
    logic oe_d = 1'b0;
    initial begin
        line_low = 1'b0;
        demag_end = 1'b0;
    end
    // Answers a wake only after the pulse ends, as a slow controller would
    always @(posedge clk) begin
        oe_d <= wake_oe;
        demag_end <= 1'b0;
        if (n > 0) begin
            n <= n - 1;
            line_low <= (n > 1);
            demag_end <= (n == 1);
        end else if (kick || (respond && oe_d && !wake_oe)) begin
            n <= low_len;
            line_low <= 1'b1;
        end
    end
endmodule

// File: tb/test_droop_wake_monitor_sequencer.sv
module test_droop_wake_monitor_sequencer;
    import dwms_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
    $display("unexpected %s exp %h got %h", n, e, g); end end
    logic             clk = 0, rst_n = 0, undervoltage_lockout = 0, wl = 0, dm = 0, kick = 0, resp = 0;
    logic [VDD_W-1:0] vdd = '0, dref;
    logic [7:0]       len = 8'h28;
    logic             woe, eoe, valid, pl, pd, wo, eo;
    int               mismatches = 0, n_compared = 0, i;
    dwms_top #(.HOLD_CYCLES(100)) DUT (.CLK_IN(clk), .RST_N_IN(rst_n), .UNDERVOLTAGE_LOCKOUT_OK_IN(undervoltage_lockout),
        .WAKE_LOW_IN(wl), .DEMAG_END_IN(dm), .VDD_SAMPLE_IN(vdd), .WAKE_OUT(wo),
        .WAKE_OE_OUT(woe), .ENABLE_OUT(eo), .ENABLE_OE_OUT(eoe), .REF_VALID_OUT(valid),
        .DROOP_REF_OUT(dref));
    dwms_primary_model PM (.clk(clk), .kick(kick), .respond(resp), .wake_oe(woe),
        .low_len(len), .line_low(pl), .demag_end(pd));
    initial forever #25 clk = ~clk;
    // Wake line is low if either side pulls it
    always @(posedge clk) begin
        wl <= pl | woe;
        dm <= pd;
    end
    function automatic logic [11:0] pct(int v);
        return 12'(v * 32'h61 / 32'h64);
    endfunction
    task pcycle(logic [7:0] l);
        @(posedge clk);
        len <= l;
        kick <= 1'b1;
        @(posedge clk);
        kick <= 1'b0;
        repeat (70) @(posedge clk);
        @(negedge clk);
    endtask
    task t_lockout();
        pcycle(8'h28);
        `CHK("ref", 12'h000, dref)
        `CHK("valid", 1'b0, valid)
        @(posedge clk);
        undervoltage_lockout <= 1'b1;
        repeat (5) @(posedge clk);
        $display("lockout done");
    endtask
    task t_qual();
        vdd <= 12'h3E8;
        pcycle(8'h28);
        `CHK("ref", pct(1000), dref)
        `CHK("valid", 1'b1, valid)
        pcycle(8'h0A);
        `CHK("ref", pct(1000), dref)
        @(posedge clk);
        vdd <= 12'h3D4;
        pcycle(8'h28);
        `CHK("ref", pct(980), dref)
        `CHK("wake", 1'b0, woe)
        $display("qualify done");
    endtask
    task t_wake();
        @(posedge clk);
        vdd <= 12'h3B0;
        for (i = 0; woe !== 1'b1 && i < 5; i++) @(negedge clk);
        `CHK("wake", 1'b1, woe)
        `CHK("wake level", 1'b0, wo)
        for (i = 0; woe === 1'b1 && i < 20; i++) @(negedge clk);
        `CHK("width", 10, i)
        for (i = 10; woe !== 1'b1 && i < 800; i++) @(negedge clk);
        `CHK("period", 600, i)
        @(posedge clk);
        resp <= 1'b1;
        repeat (100) @(negedge clk);
        `CHK("ref", pct(944), dref)
        for (i = 0; woe !== 1'b1 && i < 700; i++) @(negedge clk);
        `CHK("quiet", 700, i)
        `CHK("enable", 1'b0, eoe)
        `CHK("enable level", 1'b0, eo)
        $display("wake done");
    endtask
    task t_hold_undervoltage_lockout();
        repeat (130) @(negedge clk);
        `CHK("valid", 1'b0, valid)
        `CHK("ref", pct(944), dref)
        pcycle(8'h28);
        `CHK("valid", 1'b1, valid)
        @(posedge clk);
        undervoltage_lockout <= 1'b0;
        repeat (6) @(negedge clk);
        `CHK("ref", 12'h000, dref)
        `CHK("valid", 1'b0, valid)
        $display("hold and lockout done");
    endtask
    task report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        #500000;
        mismatches++;
        report_and_stop();
    end
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        t_lockout();
        t_qual();
        t_wake();
        t_hold_undervoltage_lockout();
        report_and_stop();
    end
endmodule
